// *** pkg/tmr8_pkg.sv ***
// Constants, register map and state layout of the 8-bit compare timer
package tmr8_pkg;

    // =========================================================
    // Register word indices (byte address = index * 4)
    localparam logic [2:0] IDX_CTRL  = 3'h0;
    localparam logic [2:0] IDX_COUNT = 3'h1;
    localparam logic [2:0] IDX_CMP   = 3'h2;
    localparam logic [2:0] IDX_FLAGS = 3'h3;
    localparam logic [2:0] IDX_PORT  = 3'h4;

    // =========================================================
    // Field positions
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_ACT_LSB   = 2;
    localparam int CTRL_FORCE_BIT = 4;
    localparam int CTRL_CS_LSB    = 5;
    localparam int FLAG_OVF_BIT   = 0;
    localparam int FLAG_MATCH_BIT = 1;
    localparam int PORT_OUT_BIT   = 0;
    localparam int PORT_DIR_BIT   = 1;
    localparam int PORT_OC_BIT    = 2;
    localparam int PORT_PIN_BIT   = 3;

    // =========================================================
    // Waveform modes and output actions
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_PHASE  = 2'h1;
    localparam logic [1:0] MODE_CLR_MATCH = 2'h2;
    localparam logic [1:0] MODE_FAST   = 2'h3;
    localparam logic [1:0] ACT_OFF     = 2'h0;
    localparam logic [1:0] ACT_TOGGLE  = 2'h1;
    localparam logic [1:0] ACT_CLEAR   = 2'h2;
    localparam logic [1:0] ACT_SET     = 2'h3;

    // =========================================================
    // Counter extremes and prescaler
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX    = 8'hff;
    localparam logic [2:0] CS_STOP    = 3'h0;
    localparam logic [2:0] CS_DIV1    = 3'h1;
    localparam logic [2:0] CS_DIV8    = 3'h2;
    localparam logic [2:0] CS_DIV64   = 3'h3;
    localparam logic [2:0] CS_DIV256  = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [9:0] PRE_LAST_1    = 10'h000;
    localparam logic [9:0] PRE_LAST_8    = 10'h007;
    localparam logic [9:0] PRE_LAST_64   = 10'h03f;
    localparam logic [9:0] PRE_LAST_256  = 10'h0ff;
    localparam logic [9:0] PRE_LAST_1024 = 10'h3ff;

    // =========================================================
    // Whole state of the timer
    typedef struct packed {
        logic [7:0]  cnt;
        logic [7:0]  ocr;
        logic [7:0]  ocr_buf;
        logic [1:0]  mode;
        logic [1:0]  act;
        logic [2:0]  cs;
        logic        port_out;
        logic        dir;
        logic        ovf;
        logic        mat;
        logic        oc;
        logic        block;
        logic [9:0]  presc;
        logic        ack;
        logic [31:0] rdata;
        logic [1:0]  pin_sync;
    } tmr8_state_s;

    localparam tmr8_state_s STATE_RST = '0;

endpackage

// *** core/tmr8_core.sv ***
// 8-bit timer with compare output, normal, clear-on-match and fast PWM
`timescale 1ns/10ps
`default_nettype none
module tmr8_core #(
    parameter int ADDR_W = 5                // Byte address width
) (
    input  wire logic              clk_sys_i,     // System clock 100 MHz
    input  wire logic              nrst_i,        // Async reset, low
    input  wire logic [ADDR_W-1:0] address_i,     // Avalon byte address
    input  wire logic              read_i,        // Avalon read
    input  wire logic              write_i,       // Avalon write
    input  wire logic [31:0]       writedata_i,   // Avalon write data
    input  wire logic [3:0]        byteenable_i,  // Avalon byte enables
    output logic [31:0]            readdata_o,    // Avalon read data
    output logic                   waitrequest_o, // Avalon wait
    input  wire logic              pin_i,         // Pin level in
    output logic                   pin_o,         // Pin level out
    output logic                   pin_oe_n_o     // Pin driver on, low
);

    // =========================================================
    // Parameter check
    generate
        if (ADDR_W < 5)
        begin : g_bad_addr
            $error("tmr8_core: ADDR_W must be at least 5");
        end
    endgenerate

    tmr8_pkg::tmr8_state_s s_reg;
    tmr8_pkg::tmr8_state_s s_next;

    // =========================================================
    // Bus decode
    logic [2:0]  idx;
    logic        mapped;
    logic        req;
    logic        wr_go;
    logic        ctrl_wr;
    logic        cnt_wr;
    logic        cmp_wr;
    logic        flg_wr;
    logic        port_wr;
    logic [31:0] rd_mux;
    logic [7:0]  wbyte;

    assign idx    = address_i[4:2];
    assign mapped = ((address_i >> 5) == '0)
                 && (address_i[1:0] == 2'h0)
                 && (idx <= tmr8_pkg::IDX_PORT);
    assign req    = read_i | write_i;
    // One wait state: answer at the second edge of each request
    assign waitrequest_o = req & ~s_reg.ack;
    assign wr_go  = write_i & s_reg.ack & byteenable_i[0] & mapped;
    assign wbyte  = writedata_i[7:0];
    assign ctrl_wr = wr_go && (idx == tmr8_pkg::IDX_CTRL);
    assign cnt_wr  = wr_go && (idx == tmr8_pkg::IDX_COUNT);
    assign cmp_wr  = wr_go && (idx == tmr8_pkg::IDX_CMP);
    assign flg_wr  = wr_go && (idx == tmr8_pkg::IDX_FLAGS);
    assign port_wr = wr_go && (idx == tmr8_pkg::IDX_PORT);

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (mapped)
        begin
            unique case (idx)
                tmr8_pkg::IDX_CTRL:
                begin
                    rd_mux[tmr8_pkg::CTRL_MODE_LSB +: 2] = s_reg.mode;
                    rd_mux[tmr8_pkg::CTRL_ACT_LSB +: 2]  = s_reg.act;
                    rd_mux[tmr8_pkg::CTRL_CS_LSB +: 3]   = s_reg.cs;
                end
                tmr8_pkg::IDX_COUNT: rd_mux[7:0] = s_reg.cnt;
                tmr8_pkg::IDX_CMP:   rd_mux[7:0] = s_reg.ocr_buf;
                tmr8_pkg::IDX_FLAGS:
                begin
                    rd_mux[tmr8_pkg::FLAG_OVF_BIT]   = s_reg.ovf;
                    rd_mux[tmr8_pkg::FLAG_MATCH_BIT] = s_reg.mat;
                end
                tmr8_pkg::IDX_PORT:
                begin
                    rd_mux[tmr8_pkg::PORT_OUT_BIT] = s_reg.port_out;
                    rd_mux[tmr8_pkg::PORT_DIR_BIT] = s_reg.dir;
                    rd_mux[tmr8_pkg::PORT_OC_BIT]  = s_reg.oc;
                    rd_mux[tmr8_pkg::PORT_PIN_BIT] = s_reg.pin_sync[1];
                end
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // =========================================================
    // Timer clock enable from prescaler
    logic [9:0] pre_last;
    logic       tick;

    always_comb
    begin
        unique case (s_reg.cs)
            tmr8_pkg::CS_DIV1:    pre_last = tmr8_pkg::PRE_LAST_1;
            tmr8_pkg::CS_DIV8:    pre_last = tmr8_pkg::PRE_LAST_8;
            tmr8_pkg::CS_DIV64:   pre_last = tmr8_pkg::PRE_LAST_64;
            tmr8_pkg::CS_DIV256:  pre_last = tmr8_pkg::PRE_LAST_256;
            tmr8_pkg::CS_DIV1024: pre_last = tmr8_pkg::PRE_LAST_1024;
            default:              pre_last = tmr8_pkg::PRE_LAST_1024;
        endcase
    end

    // Codes 6 and 7 stop the count as stop does, but the prescaler keeps running
    assign tick = (s_reg.cs != tmr8_pkg::CS_STOP)
               && (s_reg.cs <= tmr8_pkg::CS_DIV1024)
               && (s_reg.presc == pre_last);

    // =========================================================
    // Compare and waveform events
    logic       match_hit;
    logic       at_max;
    logic       is_pwm;
    logic [1:0] new_mode;
    logic [1:0] new_act;
    logic       force_go;

    // Equality is checked while the count stands; flag lands on the same edge as the count step
    assign match_hit = tick && (s_reg.cnt == s_reg.ocr)
                    && !s_reg.block;
    assign at_max    = tick && (s_reg.cnt == tmr8_pkg::CNT_MAX);
    assign is_pwm    = s_reg.mode[0];
    assign new_mode  = wbyte[tmr8_pkg::CTRL_MODE_LSB +: 2];
    assign new_act   = wbyte[tmr8_pkg::CTRL_ACT_LSB +: 2];
    // Strobe takes the action bits written with it; ignored if the mode written with it is PWM
    assign force_go  = ctrl_wr && wbyte[tmr8_pkg::CTRL_FORCE_BIT]
                    && !new_mode[0];

    function automatic logic act_nonpwm(input logic [1:0] a,
                                        input logic       o);
        logic r;
        r = o;
        unique case (a)
            tmr8_pkg::ACT_TOGGLE: r = ~o;
            tmr8_pkg::ACT_CLEAR:  r = 1'b0;
            tmr8_pkg::ACT_SET:    r = 1'b1;
            default:              r = o;
        endcase
        return r;
    endfunction

    // =========================================================
    // Next state
    always_comb
    begin
        s_next = s_reg;
        s_next.pin_sync = {s_reg.pin_sync[0], pin_i};

        // Bus handshake and read data capture
        s_next.ack = req & ~s_reg.ack;
        if (read_i && !s_reg.ack)
        begin
            s_next.rdata = rd_mux;
        end

        // Prescaler
        if (tick || (s_reg.cs == tmr8_pkg::CS_STOP))
        begin
            s_next.presc = 10'h000;
        end
        else
        begin
            s_next.presc = s_reg.presc + 10'h001;
        end

        // Counting: sequence set by the mode bits, with the top set by the compare value in clear on match
        if (tick)
        begin
            s_next.block = 1'b0;
            unique case (s_reg.mode)
                tmr8_pkg::MODE_CLR_MATCH:
                begin
                    if (match_hit)
                    begin
                        s_next.cnt = tmr8_pkg::CNT_BOTTOM;
                    end
                    else
                    begin
                        // Unbuffered top: a low top means wrap first
                        s_next.cnt = s_reg.cnt + 8'h01;
                    end
                end
                tmr8_pkg::MODE_FAST:
                    s_next.cnt = s_reg.cnt + 8'h01;
                default:
                    s_next.cnt = s_reg.cnt + 8'h01;
            endcase
        end

        // Overflow at max in every implemented mode
        if (flg_wr && wbyte[tmr8_pkg::FLAG_OVF_BIT])
        begin
            s_next.ovf = 1'b0;
        end
        if (at_max)
        begin
            s_next.ovf = 1'b1;
        end

        // Match flag; set wins over a same-cycle clear
        if (flg_wr && wbyte[tmr8_pkg::FLAG_MATCH_BIT])
        begin
            s_next.mat = 1'b0;
        end
        if (match_hit)
        begin
            s_next.mat = 1'b1;
        end

        // Compare register: buffered in PWM modes
        if (is_pwm && at_max)
        begin
            s_next.ocr = s_reg.ocr_buf;
        end
        if (cmp_wr)
        begin
            s_next.ocr_buf = wbyte;
            if (!is_pwm)
            begin
                s_next.ocr = wbyte;
            end
        end

        // Compare output; action bits read at the match
        if (match_hit)
        begin
            unique case (s_reg.mode)
                tmr8_pkg::MODE_NORMAL,
                tmr8_pkg::MODE_CLR_MATCH:
                    s_next.oc = act_nonpwm(s_reg.act, s_reg.oc);
                tmr8_pkg::MODE_FAST:
                    s_next.oc = act_nonpwm(s_reg.act, s_reg.oc);
                default:
                    s_next.oc = s_reg.oc;
            endcase
        end
        // Bottom edge wins over a match at max: constant level
        if (at_max && (s_reg.mode == tmr8_pkg::MODE_FAST))
        begin
            if (s_reg.act == tmr8_pkg::ACT_CLEAR)
            begin
                s_next.oc = 1'b1;
            end
            else if (s_reg.act == tmr8_pkg::ACT_SET)
            begin
                s_next.oc = 1'b0;
            end
        end
        // Forced match: output only, no flag, no counter change
        if (force_go)
        begin
            s_next.oc = act_nonpwm(new_act, s_reg.oc);
        end

        // Control writes
        if (ctrl_wr)
        begin
            s_next.mode = new_mode;
            s_next.act  = new_act;
            s_next.cs   = wbyte[tmr8_pkg::CTRL_CS_LSB +: 3];
        end
        if (port_wr)
        begin
            s_next.port_out = wbyte[tmr8_pkg::PORT_OUT_BIT];
            s_next.dir      = wbyte[tmr8_pkg::PORT_DIR_BIT];
        end

        // Count write beats counting and masks a match at the next tick
        if (cnt_wr)
        begin
            s_next.cnt   = wbyte;
            s_next.block = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s_reg <= tmr8_pkg::STATE_RST;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // =========================================================
    // Outputs
    assign readdata_o = s_reg.rdata;
    // Override does not depend on the mode
    assign pin_o = (s_reg.act != tmr8_pkg::ACT_OFF) ? s_reg.oc
                                                     : s_reg.port_out;
    assign pin_oe_n_o = ~s_reg.dir;

    // =========================================================
    // Assertions
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);

    sequence max_tick_s;
        at_max && !cnt_wr && !ctrl_wr;
    endsequence

    sequence fast_clear_mode_s;
        (s_reg.mode == tmr8_pkg::MODE_FAST)
        && (s_reg.act == tmr8_pkg::ACT_CLEAR);
    endsequence

    pin_override_a: assert property (
        (s_reg.act != tmr8_pkg::ACT_OFF) && s_reg.dir
        |-> !pin_oe_n_o && (pin_o == s_reg.oc))
        else $error("pin not driven by compare output");

    act_zero_hold_a: assert property (
        (s_reg.act == tmr8_pkg::ACT_OFF) && !ctrl_wr
        |=> s_reg.oc == $past(s_reg.oc))
        else $error("output bit moved with action zero");

    normal_count_a: assert property (
        (s_reg.mode == tmr8_pkg::MODE_NORMAL) && tick
        && !cnt_wr && !ctrl_wr
        |=> s_reg.cnt == $past(s_reg.cnt) + 8'h01)
        else $error("normal mode did not increment");

    ovf_at_max_a: assert property (
        max_tick_s |=> s_reg.ovf && (s_reg.cnt == tmr8_pkg::CNT_BOTTOM))
        else $error("overflow not set on wrap");

    clear_match_a: assert property (
        (s_reg.mode == tmr8_pkg::MODE_CLR_MATCH) && match_hit && !cnt_wr
        |=> s_reg.cnt == tmr8_pkg::CNT_BOTTOM)
        else $error("clear on match missed");

    match_flag_a: assert property (
        (tick && (s_reg.cnt == s_reg.ocr) && !s_reg.block)
        |=> s_reg.mat)
        else $error("match flag not set");

    count_block_a: assert property (
        cnt_wr ##1 tick && !cnt_wr && !flg_wr
        |=> s_reg.mat == $past(s_reg.mat))
        else $error("match not blocked after count write");

    force_noflag_a: assert property (
        force_go && !tick && !flg_wr
        |=> (s_reg.mat == $past(s_reg.mat))
            && (s_reg.cnt == $past(s_reg.cnt)))
        else $error("force touched flag or counter");

    fast_bottom_a: assert property (
        fast_clear_mode_s and max_tick_s |=> s_reg.oc)
        else $error("fast mode bottom did not set output");

    fast_buffer_a: assert property (
        (s_reg.mode == tmr8_pkg::MODE_FAST) && !at_max
        |=> s_reg.ocr == $past(s_reg.ocr))
        else $error("compare changed away from bottom");

    bus_answer_a: assert property (
        req && waitrequest_o |=> !waitrequest_o [*1] ##1 1'b1)
        else $error("bus answer late");

endmodule
`default_nettype wire

// *** test/tmr8_pin_model.sv ***
// Port pin model with an external pull-up, seen by the compare timer
`timescale 1ns/10ps
`default_nettype none
module tmr8_pin_model #(
    parameter logic PULL_LVL = 1'b1         // Level of a released pin
) (
    input  wire logic drv_i,                // Level the timer drives
    input  wire logic drv_oe_n_i,           // Driver on, low
    output logic      pin_lvl_o             // Resolved pin level
);
    // ==========================================================
    // Pin resolution
    // A released pin never keeps the last driven value
    assign pin_lvl_o = drv_oe_n_i ? PULL_LVL : drv_i;
endmodule
`default_nettype wire

// *** test/timer8_compare_wave_modes_bench.sv ***
// Register-level bench of the compare timer and its pin
`timescale 1ns/10ps
`default_nettype none
module timer8_compare_wave_modes_bench;
    // ==========================================================
    // Signals
    localparam int LIMIT = 60000;           // Tests need about 6000
    logic        clk_sys_i;
    logic        nrst_i;
    logic [4:0]  address_i;
    logic        read_i;
    logic        write_i;
    logic [31:0] writedata_i;
    logic [3:0]  byteenable_i;
    logic [31:0] readdata_o;
    logic        waitrequest_o;
    logic        pin_o;
    logic        pin_oe_n_o;
    logic        pin_lvl;
    logic [31:0] rv;
    int          error_cnt;
    int          n_compared;
    int          cyc;
    int          lows;
    logic [1:0]  f_act [4] = '{2'h2, 2'h3, 2'h2, 2'h1};
    logic [7:0]  f_cmp [4] = '{8'h3f, 8'h3f, 8'h00, 8'h00};
    int          f_hi  [4] = '{64, 192, 1, 256};
    int          f_per [4] = '{256, 256, 256, 512};

    tmr8_core i_tmr8_core (
        .clk_sys_i     (clk_sys_i),
        .nrst_i        (nrst_i),
        .address_i     (address_i),
        .read_i        (read_i),
        .write_i       (write_i),
        .writedata_i   (writedata_i),
        .byteenable_i  (byteenable_i),
        .readdata_o    (readdata_o),
        .waitrequest_o (waitrequest_o),
        .pin_i         (pin_lvl),
        .pin_o         (pin_o),
        .pin_oe_n_o    (pin_oe_n_o)
    );

    tmr8_pin_model i_tmr8_pin_model (
        .drv_i      (pin_o),
        .drv_oe_n_i (pin_oe_n_o),
        .pin_lvl_o  (pin_lvl)
    );

    // ==========================================================
    // Tasks
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Request held until waitrequest is sampled low
    task automatic xfer(input logic rd, input logic [2:0] idx,
                        input logic [7:0] d, input logic [3:0] be);
        address_i <= {idx, 2'h0};
        writedata_i <= {24'h0, d};
        byteenable_i <= be;
        read_i <= rd;
        write_i <= ~rd;
        do
        begin
            @(posedge clk_sys_i);
        end
        while (waitrequest_o !== 1'b0);
        rv = readdata_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task automatic wr(input logic [2:0] idx, input logic [7:0] d,
                      input logic [3:0] be = 4'h1);
        xfer(1'b0, idx, d, be);
    endtask

    task automatic rdchk(input logic [2:0] idx, input logic [7:0] exp);
        xfer(1'b1, idx, 8'h00, 4'h0);
        check($sformatf("reg%0d", idx), rv, exp);
    endtask

    task automatic setc(input logic [1:0] m, input logic [1:0] a,
                        input logic f, input logic [2:0] cs);
        wr(tmr8_pkg::IDX_CTRL, {cs, f, a, m});
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    task automatic hold(input logic lv, inout int n);
        while (pin_lvl === lv && n < 3000)
        begin
            @(posedge clk_sys_i);
            n++;
        end
    endtask

    // Skips a partial period, then times one whole period
    task automatic meas(input int ehi, input int eper);
        int n;
        int m;
        n = 0;
        hold(1'b1, n);
        hold(1'b0, n);
        m = n;
        hold(1'b1, n);
        check("high time", n - m, ehi);
        hold(1'b0, n);
        check("period", n - m, eper);
    endtask

    task automatic results();
        $display("Compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ==========================================================
    // Clock and timeout
    initial
    begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            error_cnt++;
            results();
        end
    end

    // ==========================================================
    // Tests
    initial
    begin
        nrst_i = 1'b0;
        address_i = '0;
        read_i = 1'b0;
        write_i = 1'b0;
        writedata_i = '0;
        byteenable_i = '0;
        error_cnt = 0;
        n_compared = 0;
        idle(12);
        nrst_i <= 1'b1;
        @(posedge clk_sys_i);
        check("driver off", pin_oe_n_o, 1'b1);
        rdchk(tmr8_pkg::IDX_CTRL, 8'h00);
        rdchk(tmr8_pkg::IDX_FLAGS, 8'h00);
        rdchk(tmr8_pkg::IDX_PORT, 8'h08);
        rdchk(3'h5, 8'h00);
        wr(tmr8_pkg::IDX_COUNT, 8'h55, 4'h0);
        rdchk(tmr8_pkg::IDX_COUNT, 8'h00);
        // Output bit prepared by force while the driver is off
        setc(tmr8_pkg::MODE_NORMAL, tmr8_pkg::ACT_SET, 1'b1, 3'h0);
        rdchk(tmr8_pkg::IDX_PORT, 8'h0c);
        rdchk(tmr8_pkg::IDX_FLAGS, 8'h00);
        setc(tmr8_pkg::MODE_NORMAL, tmr8_pkg::ACT_CLEAR, 1'b1, 3'h0);
        rdchk(tmr8_pkg::IDX_PORT, 8'h08);
        setc(tmr8_pkg::MODE_NORMAL, tmr8_pkg::ACT_TOGGLE, 1'b1, 3'h0);
        rdchk(tmr8_pkg::IDX_PORT, 8'h0c);
        wr(tmr8_pkg::IDX_PORT, 8'h02);
        idle(3);
        check("pin override", pin_lvl, 1'b1);
        setc(tmr8_pkg::MODE_NORMAL, tmr8_pkg::ACT_OFF, 1'b0, 3'h0);
        idle(3);
        check("pin from port", pin_lvl, 1'b0);
        // Normal mode wrap with matches passing, action off
        wr(tmr8_pkg::IDX_COUNT, 8'hfe);
        rdchk(tmr8_pkg::IDX_COUNT, 8'hfe);
        wr(tmr8_pkg::IDX_CMP, 8'h00);
        setc(tmr8_pkg::MODE_NORMAL, tmr8_pkg::ACT_OFF, 1'b0, 3'h1);
        idle(10);
        rdchk(tmr8_pkg::IDX_FLAGS, 8'h03);
        setc(tmr8_pkg::MODE_NORMAL, tmr8_pkg::ACT_OFF, 1'b0, 3'h0);
        xfer(1'b1, tmr8_pkg::IDX_COUNT, 8'h00, 4'h0);
        check("wrapped", rv < 8'h20, 1'b1);
        rdchk(tmr8_pkg::IDX_PORT, 8'h06);
        wr(tmr8_pkg::IDX_FLAGS, 8'h03);
        rdchk(tmr8_pkg::IDX_FLAGS, 8'h00);
        // Clear on match, toggling
        wr(tmr8_pkg::IDX_COUNT, 8'h00);
        wr(tmr8_pkg::IDX_CMP, 8'h03);
        setc(tmr8_pkg::MODE_CLR_MATCH, tmr8_pkg::ACT_TOGGLE, 1'b0, 3'h1);
        meas(4, 8);
        wr(tmr8_pkg::IDX_CMP, 8'h00);
        meas(1, 2);
        wr(tmr8_pkg::IDX_FLAGS, 8'h03);
        idle(20);
        rdchk(tmr8_pkg::IDX_FLAGS, 8'h02);
        // Count write while running masks the next match
        wr(tmr8_pkg::IDX_COUNT, 8'h00);
        wr(tmr8_pkg::IDX_FLAGS, 8'h03);
        idle(20);
        rdchk(tmr8_pkg::IDX_FLAGS, 8'h00);
        wr(tmr8_pkg::IDX_COUNT, 8'hff);
        setc(tmr8_pkg::MODE_CLR_MATCH, tmr8_pkg::ACT_TOGGLE, 1'b0,
             tmr8_pkg::CS_DIV8);
        meas(8, 16);
        // Compare written below the count: runs on through the wrap
        setc(tmr8_pkg::MODE_CLR_MATCH, tmr8_pkg::ACT_TOGGLE, 1'b0, 3'h0);
        wr(tmr8_pkg::IDX_COUNT, 8'h80);
        wr(tmr8_pkg::IDX_CMP, 8'h10);
        wr(tmr8_pkg::IDX_FLAGS, 8'h03);
        setc(tmr8_pkg::MODE_CLR_MATCH, tmr8_pkg::ACT_TOGGLE, 1'b0, 3'h1);
        idle(50);
        rdchk(tmr8_pkg::IDX_FLAGS, 8'h00);
        idle(250);
        rdchk(tmr8_pkg::IDX_FLAGS, 8'h03);
        // Fast PWM polarities, extremes and toggle
        for (int i = 0; i < 4; i++)
        begin
            setc(tmr8_pkg::MODE_FAST, f_act[i], 1'b0, 3'h1);
            wr(tmr8_pkg::IDX_CMP, f_cmp[i]);
            idle(600);
            meas(f_hi[i], f_per[i]);
        end
        setc(tmr8_pkg::MODE_FAST, tmr8_pkg::ACT_CLEAR, 1'b0, 3'h1);
        wr(tmr8_pkg::IDX_CMP, 8'hff);
        rdchk(tmr8_pkg::IDX_CMP, 8'hff);
        idle(600);
        wr(tmr8_pkg::IDX_FLAGS, 8'h03);
        lows = 0;
        repeat (300)
        begin
            @(posedge clk_sys_i);
            if (pin_lvl !== 1'b1)
                lows++;
        end
        check("constant high", lows, 0);
        rdchk(tmr8_pkg::IDX_FLAGS, 8'h03);
        results();
    end
endmodule
`default_nettype wire
